// *** dcfifo_cfg.svh ***
`ifndef DCFIFO_CFG_SVH
`define DCFIFO_CFG_SVH

// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define OFS_STATUS 12'h000
`define OFS_MASK 12'h004
`define OFS_CTRL 12'h008
`define OFS_LEVEL 12'h00C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EV_FULL 0
`define EV_OVERFLOW 1
`define EV_UNDERFLOW 2
`define EV_RETRANSMIT 3
`define EV_COUNT 4
`define CTRL_PORT_EN 0
`define MASK_RESET 4'h0
`define CTRL_RESET 1'b1

// ----------------------------------------
// Configuration registers
// ----------------------------------------
`define CFG_REGS 4
`define CFG_DEFAULT 8'h00

`endif

// *** dcfifo_pkg.sv ***
package dcfifo_pkg;
    // Word sizes selectable on the shared width pins
    typedef enum logic [2:0] {
        WIDTH_9 = 3'b000,
        WIDTH_12 = 3'b001,
        WIDTH_16 = 3'b010,
        WIDTH_18 = 3'b011,
        WIDTH_20 = 3'b100,
        WIDTH_24 = 3'b101,
        WIDTH_32 = 3'b110,
        WIDTH_36 = 3'b111
    } word_width_t;

    // Target of a port access
    typedef enum logic [1:0] {
        TGT_CONFIG = 2'b00,
        TGT_MEMORY = 2'b01,
        TGT_MAILBOX = 2'b10
    } access_target_t;
endpackage

// *** fifo_mem_store.sv ***
`timescale 1ns/1ps
module fifo_mem_store #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData
);
    localparam int DEPTH = 1 << ADDR_W;

    // ----------------------------------------
    // Storage array
    // ----------------------------------------
    logic [DATA_W-1:0] memArray [DEPTH];

    // No reset on the array: clears move pointers, not contents
    always_ff @(posedge clk) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
    end

    // Asynchronous read; the caller registers the result
    assign rdData = memArray[rdAddr];
endmodule

// *** dcfifo_port_ctrl.sv ***
`timescale 1ns/1ps
`include "dcfifo_cfg.svh"
module dcfifo_port_ctrl #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic full_clear_n,
    input wire logic partial_clear_n,
    input wire logic [2:0] word_width_select,
    input wire logic config_port_select,
    input wire logic mailbox_select,
    input wire logic writeStrobeN,
    input wire logic input_gate_n,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic readStrobeN,
    input wire logic outputDriveN,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOutEn,
    output logic output_valid_n,
    input wire logic positionTag,
    input wire logic retransmit_pulse,
    output logic full_indicator_n,
    output logic emptyIndicatorN,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    localparam int PTR_W = ADDR_W + 1;
    localparam logic [PTR_W-1:0] DEPTH_VAL = PTR_W'(1 << ADDR_W);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Mask of valid lanes for the shared word size
    function automatic logic [DATA_W-1:0] widthMask(input logic [2:0] sel);
        logic [5:0] bits;
        bits = 6'd36;
        case (dcfifo_pkg::word_width_t'(sel))
            dcfifo_pkg::WIDTH_9: bits = 6'd9;
            dcfifo_pkg::WIDTH_12: bits = 6'd12;
            dcfifo_pkg::WIDTH_16: bits = 6'd16;
            dcfifo_pkg::WIDTH_18: bits = 6'd18;
            dcfifo_pkg::WIDTH_20: bits = 6'd20;
            dcfifo_pkg::WIDTH_24: bits = 6'd24;
            dcfifo_pkg::WIDTH_32: bits = 6'd32;
            default: bits = 6'd36;
        endcase
        for (int i = 0; i < DATA_W; i++) begin
            widthMask[i] = (i < int'(bits));
        end
    endfunction

    // Which store a strobe reaches
    function automatic dcfifo_pkg::access_target_t targetOf(
        input logic cfgSel, input logic mbSel);
        if (mbSel) begin
            targetOf = dcfifo_pkg::TGT_MAILBOX;
        end else if (cfgSel) begin
            targetOf = dcfifo_pkg::TGT_MEMORY;
        end else begin
            targetOf = dcfifo_pkg::TGT_CONFIG;
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W-1:0] markPtr_reg;
    logic [PTR_W-1:0] shownPtr_reg;
    logic [DATA_W-1:0] dataOut_reg;
    logic valid_reg;
    logic [DATA_W-1:0] mailbox_reg;
    logic [7:0] cfg_reg [`CFG_REGS];
    logic [1:0] cfgWrIdx_reg;
    logic [1:0] cfgRdIdx_reg;
    logic [`EV_COUNT-1:0] status_reg;
    logic [`EV_COUNT-1:0] mask_reg;
    logic ctrlPortEn_reg;
    logic [`EV_COUNT-1:0] events;
    logic [`EV_COUNT-1:0] w1cBits;

    logic [PTR_W-1:0] level;
    logic isFull;
    logic isEmpty;
    logic anyClear;
    logic writeReq;
    logic readReq;
    dcfifo_pkg::access_target_t wrTarget;
    dcfifo_pkg::access_target_t rdTarget;
    logic memWrite;
    logic memAdvance;
    logic memRead;
    logic [DATA_W-1:0] laneMask;
    logic [DATA_W-1:0] memRdData;
    logic apbAccess;
    logic apbWrite;

    // ----------------------------------------
    // Occupancy and flags
    // ----------------------------------------
    // Extra pointer bit tells full from empty at equal addresses
    assign level = wrPtr_reg - rdPtr_reg;
    assign isFull = (level == DEPTH_VAL);
    assign isEmpty = (level == '0);
    assign full_indicator_n = ~isFull;
    assign emptyIndicatorN = ~isEmpty;
    assign anyClear = ~full_clear_n | ~partial_clear_n;

    // Strobes are dropped while software holds the ports off
    assign writeReq = ~writeStrobeN & ctrlPortEn_reg;
    assign readReq = ~readStrobeN & ctrlPortEn_reg;
    assign wrTarget = targetOf(config_port_select, mailbox_select);
    assign rdTarget = targetOf(config_port_select, mailbox_select);

    // Pointer moves even when the gate masks the data
    assign memAdvance = writeReq & ~anyClear & ~isFull &
        (wrTarget == dcfifo_pkg::TGT_MEMORY);
    assign memWrite = memAdvance & ~input_gate_n;
    // Read fires whatever the output drive does
    assign memRead = readReq & ~anyClear & ~isEmpty &
        (rdTarget == dcfifo_pkg::TGT_MEMORY);

    // One width for both ports
    assign laneMask = widthMask(word_width_select);

    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    fifo_mem_store #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_store (
        .clk(clk),
        .wrEn(memWrite),
        .wrAddr(wrPtr_reg[ADDR_W-1:0]),
        .wrData(dataIn & laneMask),
        .rdAddr(rdPtr_reg[ADDR_W-1:0]),
        .rdData(memRdData)
    );

    // ----------------------------------------
    // Write side
    // ----------------------------------------
    // Write pointer, wraps through the low bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
        end else if (anyClear) begin
            wrPtr_reg <= '0;
        end else if (memAdvance) begin
            wrPtr_reg <= wrPtr_reg + PTR_W'(1);
        end
    end

    // Mailbox bypasses the sequence, gated like memory
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mailbox_reg <= '0;
        end else if (writeReq && wrTarget == dcfifo_pkg::TGT_MAILBOX &&
                     !input_gate_n) begin
            mailbox_reg <= dataIn & laneMask;
        end
    end

    // Configuration bytes load in turn from the low data lanes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `CFG_REGS; i++) begin
                cfg_reg[i] <= `CFG_DEFAULT;
            end
            cfgWrIdx_reg <= '0;
        end else if (!full_clear_n) begin
            for (int i = 0; i < `CFG_REGS; i++) begin
                cfg_reg[i] <= `CFG_DEFAULT;
            end
            cfgWrIdx_reg <= '0;
        end else if (!partial_clear_n) begin
            cfgWrIdx_reg <= '0;
        end else if (writeReq && wrTarget == dcfifo_pkg::TGT_CONFIG) begin
            cfg_reg[cfgWrIdx_reg] <= dataIn[7:0];
            cfgWrIdx_reg <= cfgWrIdx_reg + 2'd1;
        end
    end

    // ----------------------------------------
    // Read side
    // ----------------------------------------
    // Read pointer; retransmit outranks a read in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdPtr_reg <= '0;
        end else if (anyClear) begin
            rdPtr_reg <= '0;
        end else if (retransmit_pulse) begin
            rdPtr_reg <= markPtr_reg;
        end else if (memRead) begin
            rdPtr_reg <= rdPtr_reg + PTR_W'(1);
        end
    end

    // Location of the word now on the output register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shownPtr_reg <= '0;
        end else if (anyClear) begin
            shownPtr_reg <= '0;
        end else if (memRead && !retransmit_pulse) begin
            shownPtr_reg <= rdPtr_reg;
        end
    end

    // Retransmit point; a clear returns it to the start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            markPtr_reg <= '0;
        end else if (anyClear) begin
            markPtr_reg <= '0;
        end else if (positionTag && valid_reg) begin
            markPtr_reg <= shownPtr_reg;
        end
    end

    // Configuration read index follows its own turn
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgRdIdx_reg <= '0;
        end else if (anyClear) begin
            cfgRdIdx_reg <= '0;
        end else if (readReq && rdTarget == dcfifo_pkg::TGT_CONFIG) begin
            cfgRdIdx_reg <= cfgRdIdx_reg + 2'd1;
        end
    end

    // Output register and its valid mark
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataOut_reg <= '0;
            valid_reg <= 1'b0;
        end else if (anyClear) begin
            dataOut_reg <= '0;
            valid_reg <= 1'b0;
        end else if (readReq) begin
            case (rdTarget)
                dcfifo_pkg::TGT_MEMORY: begin
                    if (!isEmpty) begin
                        dataOut_reg <= memRdData & laneMask;
                        valid_reg <= 1'b1;
                    end else begin
                        valid_reg <= 1'b0; // Nothing left to show
                    end
                end
                dcfifo_pkg::TGT_MAILBOX: begin
                    dataOut_reg <= mailbox_reg;
                    valid_reg <= 1'b1;
                end
                default: begin
                    dataOut_reg <= {{(DATA_W-8){1'b0}},
                        cfg_reg[cfgRdIdx_reg]};
                    valid_reg <= 1'b1;
                end
            endcase
        end
    end

    // Drive only while enabled; the pin wire resolves outside
    assign dataOut = dataOut_reg;
    assign dataOutEn = ~outputDriveN;
    assign output_valid_n = ~valid_reg;

    // ----------------------------------------
    // Event capture
    // ----------------------------------------
    assign events[`EV_FULL] = memAdvance &&
        (level == DEPTH_VAL - PTR_W'(1));
    assign events[`EV_OVERFLOW] = writeReq && !anyClear && isFull &&
        wrTarget == dcfifo_pkg::TGT_MEMORY;
    assign events[`EV_UNDERFLOW] = readReq && !anyClear && isEmpty &&
        rdTarget == dcfifo_pkg::TGT_MEMORY;
    assign events[`EV_RETRANSMIT] = retransmit_pulse && !anyClear;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Zero wait states: every access ends in its first access cycle
    assign apbAccess = psel & penable;
    assign apbWrite = apbAccess & pwrite;
    assign pready = 1'b1;

    assign w1cBits = (apbWrite && paddr == `OFS_STATUS) ?
        pwdata[`EV_COUNT-1:0] : '0;

    // Sticky bits: a new event beats a clear in the same cycle
    generate
        for (genvar g = 0; g < `EV_COUNT; g++) begin : gStatus
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    status_reg[g] <= 1'b0;
                end else if (events[g]) begin
                    status_reg[g] <= 1'b1;
                end else if (w1cBits[g]) begin
                    status_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Writable mask and control
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= `MASK_RESET;
            ctrlPortEn_reg <= `CTRL_RESET;
        end else if (apbWrite) begin
            if (paddr == `OFS_MASK) begin
                mask_reg <= pwdata[`EV_COUNT-1:0];
            end else if (paddr == `OFS_CTRL) begin
                ctrlPortEn_reg <= pwdata[`CTRL_PORT_EN];
            end
        end
    end

    // Read mux; unmapped addresses answer zero with an error
    always_comb begin
        prdata = 32'h00000000;
        pslverr = 1'b0;
        if (paddr == `OFS_STATUS) begin
            prdata[`EV_COUNT-1:0] = status_reg;
        end else if (paddr == `OFS_MASK) begin
            prdata[`EV_COUNT-1:0] = mask_reg;
        end else if (paddr == `OFS_CTRL) begin
            prdata[`CTRL_PORT_EN] = ctrlPortEn_reg;
        end else if (paddr == `OFS_LEVEL) begin
            prdata[PTR_W-1:0] = level;
            prdata[16] = isFull;
            prdata[17] = isEmpty;
        end else begin
            pslverr = apbAccess;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(status_reg & mask_reg);
endmodule

// *** dcfifo_port_ctrl_monitor.sv ***
`timescale 1ns/1ps
module dcfifo_port_ctrl_monitor #(
    parameter int DATA_W = 36
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic full_clear_n,
    input wire logic partial_clear_n,
    input wire logic config_port_select,
    input wire logic mailbox_select,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    input wire logic outputDriveN,
    input wire logic retransmit_pulse,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOutEn,
    input wire logic output_valid_n,
    input wire logic full_indicator_n,
    input wire logic emptyIndicatorN
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic run;
    logic mem;
    // Strobes only count with no clear pending
    assign run = full_clear_n && partial_clear_n;
    assign mem = run && config_port_select && !mailbox_select;

    chk_drive_pins: assert property (
        dataOutEn == !outputDriveN) else $error("pin enable wrong");
    chk_full_clear: assert property (
        !full_clear_n |=> dataOut == '0 && output_valid_n && !emptyIndicatorN)
        else $error("full clear left state");
    chk_part_clear: assert property (
        !partial_clear_n |=> dataOut == '0 && full_indicator_n
        && !emptyIndicatorN) else $error("partial clear left state");
    chk_read_empty: assert property (
        mem && !readStrobeN && !emptyIndicatorN && !retransmit_pulse
        |=> output_valid_n) else $error("valid on empty read");
    chk_read_word: assert property (
        mem && !readStrobeN && emptyIndicatorN && !retransmit_pulse
        |=> !output_valid_n) else $error("read gave no word");
    chk_write_fills: assert property (
        mem && !writeStrobeN |=> emptyIndicatorN)
        else $error("write did not advance");
    chk_mailbox_word: assert property (
        run && mailbox_select && !readStrobeN |=> !output_valid_n)
        else $error("mailbox read invalid");
    chk_hold_output: assert property (
        run && readStrobeN |=> $stable(dataOut) && $stable(output_valid_n))
        else $error("output moved without read");
    chk_full_hold: assert property (
        !full_indicator_n && readStrobeN && run && !retransmit_pulse
        |=> !full_indicator_n) else $error("full dropped without read");
endmodule

bind dcfifo_port_ctrl dcfifo_port_ctrl_monitor #(.DATA_W(DATA_W)) mon_i (
    .clk, .sys_rst, .full_clear_n, .partial_clear_n, .config_port_select,
    .mailbox_select, .writeStrobeN, .readStrobeN, .outputDriveN,
    .retransmit_pulse, .dataOut, .dataOutEn, .output_valid_n,
    .full_indicator_n, .emptyIndicatorN);

// *** fifo_host_model.sv ***
`timescale 1ns/1ps
module fifo_host_model (
    input wire logic clk,
    output logic writeStrobeN,
    output logic input_gate_n,
    output logic [35:0] dataIn,
    output logic readStrobeN,
    output logic outputDriveN,
    output logic positionTag,
    output logic retransmit_pulse
);
    initial begin
        writeStrobeN = 1'b1;
        input_gate_n = 1'b1;
        dataIn = 36'h5A5A5A5A5;
        readStrobeN = 1'b1;
        outputDriveN = 1'b1;
        positionTag = 1'b0;
        retransmit_pulse = 1'b0;
    end
    // One word per call; it is taken at the following edge
    task automatic put(input logic [35:0] w, input logic gate);
        @(posedge clk);
        writeStrobeN <= 1'b0;
        input_gate_n <= !gate;
        dataIn <= w;
    endtask
    // One read; the word shows after the following edge
    task automatic take(input logic drive);
        @(posedge clk);
        readStrobeN <= 1'b0;
        outputDriveN <= !drive;
    endtask
    // Mark or retransmit for one edge
    task automatic tag(input logic rt);
        @(posedge clk);
        positionTag <= !rt;
        retransmit_pulse <= rt;
    endtask
    // Release strobes, tag and retransmit (gate and drive hold); the idle bus flips so stale data never looks valid
    task automatic idle();
        @(posedge clk);
        writeStrobeN <= 1'b1;
        readStrobeN <= 1'b1;
        positionTag <= 1'b0;
        retransmit_pulse <= 1'b0;
        dataIn <= ~dataIn;
    endtask
endmodule

// *** dual_clock_fifo_port_control_tb.sv ***
`timescale 1ns/1ps
`include "dcfifo_cfg.svh"
module dual_clock_fifo_port_control_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic full_clear_n = 1'b1;
    logic partial_clear_n = 1'b1;
    logic [2:0] word_width_select = dcfifo_pkg::WIDTH_36;
    logic config_port_select = 1'b1;
    logic mailbox_select = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic writeStrobeN, input_gate_n, readStrobeN, outputDriveN;
    logic positionTag, retransmit_pulse, dataOutEn, output_valid_n;
    logic full_indicator_n, emptyIndicatorN, pready, pslverr, irq;
    logic [35:0] dataIn, dataOut, wmask = 36'hFFFFFFFFF;
    logic [31:0] prdata;
    logic [35:0] mem [16];
    logic [15:0] lfsr = 16'h003F;
    int wp, rp, lvl, mk, badCount, totalChecks;

    always #12.5 clk = ~clk;

    fifo_host_model host_i (.clk, .writeStrobeN, .input_gate_n, .dataIn,
        .readStrobeN, .outputDriveN, .positionTag, .retransmit_pulse);
    dcfifo_port_ctrl dcfifo_port_ctrl_i (.clk, .sys_rst, .full_clear_n,
        .partial_clear_n, .word_width_select, .config_port_select,
        .mailbox_select, .writeStrobeN, .input_gate_n, .dataIn, .readStrobeN,
        .outputDriveN, .dataOut, .dataOutEn, .output_valid_n, .positionTag,
        .retransmit_pulse, .full_indicator_n, .emptyIndicatorN, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

    // ------------------------------
    // Checking and bus helpers
    // ------------------------------
    function automatic logic [35:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return {lfsr[3:0], lfsr, lfsr};
    endfunction
    task automatic report(input logic [35:0] got, input logic [35:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_data(input logic [35:0] g, input logic [35:0] e);
        report(g, e);
    endtask
    task automatic cmp_flag(input logic g, input logic e);
        report({35'h0, g}, {35'h0, e});
    endtask
    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        report({4'h0, g}, {4'h0, e});
    endtask
    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] e, input logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 20);
        if (!pready) begin
            badCount++;
            stopTest();
        end
        if (!w) cmp_reg(prdata, e);
        cmp_flag(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the write land before the caller looks at irq
        #1;
    endtask
    task automatic wr(input int n, input logic gate);
        logic [35:0] w;
        for (int i = 0; i < n; i++) begin
            w = rnd();
            host_i.put(w, gate);
            if (lvl < 16) begin
                if (gate) mem[wp] = w & wmask;
                wp = (wp + 1) % 16;
                lvl++;
            end
        end
        host_i.idle();
        // Flags settle after the last write edge
        #1;
    endtask
    task automatic rd(input logic drive);
        host_i.take(drive);
        host_i.idle();
        #1;
        cmp_flag(dataOutEn, drive);
        // Config reads always carry a word; memory ones only when filled
        cmp_flag(output_valid_n, config_port_select && lvl == 0);
        if (config_port_select && lvl > 0) begin
            cmp_data(dataOut, mem[rp]);
            rp = (rp + 1) % 16;
            lvl--;
        end
    endtask
    // Config reads walk the four bytes from index zero
    task automatic cfg_check(input logic [7:0] b, input logic [7:0] s);
        for (int i = 0; i < 4; i++) begin
            rd(1'b1);
            cmp_data({28'h0, dataOut[7:0]}, {28'h0, b + s * 8'(i)});
        end
    endtask
    task automatic clr(input logic full);
        @(posedge clk);
        full_clear_n <= !full;
        partial_clear_n <= full;
        @(posedge clk);
        full_clear_n <= 1'b1;
        partial_clear_n <= 1'b1;
        {wp, rp, lvl} = '0;
    endtask

    initial begin
        #1000000;
        badCount++;
        stopTest();
    end

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        apb(0, `OFS_CTRL, 0, 32'h1, 0);
        apb(0, `OFS_MASK, 0, 32'h0, 0);
        apb(0, 12'h010, 0, 32'h0, 1);
        $display("test reset done");
        wr(16, 1'b1);
        cmp_flag(full_indicator_n, 1'b0);
        apb(0, `OFS_LEVEL, 0, 32'h00010010, 0);
        wr(1, 1'b1);
        apb(0, `OFS_STATUS, 0, 32'h3, 0);
        cmp_flag(irq, 1'b0);
        apb(1, `OFS_MASK, 32'h2, 0, 0);
        cmp_flag(irq, 1'b1);
        apb(1, `OFS_STATUS, 32'h3, 0, 0);
        cmp_flag(irq, 1'b0);
        $display("test fill done");
        rd(1'b1);
        rd(1'b1);
        host_i.tag(1'b0);
        host_i.idle();
        mk = (rp + 15) % 16;
        rd(1'b0);
        rd(1'b1);
        host_i.tag(1'b1);
        host_i.idle();
        rp = mk;
        lvl = (wp - mk + 16) % 16;
        repeat (3) rd(1'b1);
        wr(1, 1'b1);
        wr(1, 1'b0);
        wr(1, 1'b1);
        while (lvl > 0) rd(1'b1);
        rd(1'b1);
        apb(0, `OFS_STATUS, 0, 32'hC, 0);
        apb(1, `OFS_STATUS, 32'hF, 0, 0);
        $display("test retransmit done");
        word_width_select <= dcfifo_pkg::WIDTH_9;
        wmask = 36'h1FF;
        wr(2, 1'b1);
        rd(1'b1);
        rd(1'b1);
        word_width_select <= dcfifo_pkg::WIDTH_36;
        wmask = 36'hFFFFFFFFF;
        mailbox_select <= 1'b1;
        wmask = rnd();
        host_i.put(wmask, 1'b1);
        host_i.take(1'b1);
        host_i.idle();
        #1;
        cmp_data(dataOut, wmask);
        cmp_flag(emptyIndicatorN, 1'b0);
        mailbox_select <= 1'b0;
        wmask = 36'hFFFFFFFFF;
        $display("test width mailbox done");
        wr(3, 1'b1);
        config_port_select <= 1'b0;
        for (int i = 0; i < 4; i++) host_i.put({28'h0, 8'hA5 + 8'(i)}, 1);
        host_i.idle();
        cfg_check(8'hA5, 8'h1);
        clr(1'b0);
        cfg_check(8'hA5, 8'h1);
        config_port_select <= 1'b1;
        rd(1'b1);
        config_port_select <= 1'b0;
        clr(1'b1);
        cfg_check(8'h00, 8'h0);
        $display("test clears done");
        stopTest();
    end
endmodule
